// *** hw/asd_regs.svh ***
// Timing and sequencing constants for the anti-shock DRAM access sequencer
`ifndef ASD_REGS_SVH
`define ASD_REGS_SVH

// System clock period in ns
`define ASD_CLK_PERIOD_NS 40

// Access phases, counted from the cycle the row address goes out
`define ASD_P_START 4'h0
`define ASD_P_RAS_FALL 4'h1
`define ASD_P_ROW_HOLD 4'h1
`define ASD_P_CAS_FALL 4'h3
`define ASD_P_LAST_LOW 4'h5
`define ASD_P_COL_END 4'h7
`define ASD_P_END 4'h8
`define ASD_PHASE_STEP 4'h1

// Row counts of each DRAM size
`define ASD_ROWS_1M 512
`define ASD_ROWS_4M 1024

// Whole-array refresh periods in us, per size and compression mode
`define ASD_TREF_1M_FULL_US 1400
`define ASD_TREF_1M_6B_US 3700
`define ASD_TREF_1M_5B_US 4400
`define ASD_TREF_1M_4B_US 5500
`define ASD_TREF_4M_FULL_US 2700
`define ASD_TREF_4M_6B_US 7300
`define ASD_TREF_4M_5B_US 8800
`define ASD_TREF_4M_4B_US 10900

// Cycles between single-row refreshes, rounded down
`define ASD_REF_CYC(us, rows) (((us) * 1000 / `ASD_CLK_PERIOD_NS) / (rows))
`define ASD_REF_CYC_MAX `ASD_REF_CYC(`ASD_TREF_4M_4B_US, `ASD_ROWS_4M)

// Read-data buffer depth
`define ASD_BUF_DEPTH 2'h2

`endif

// *** hw/asd_pkg.sv ***
// Types shared by the anti-shock DRAM access sequencer
package asd_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ASD_IDLE = 4'b0001,
    ASD_WRITE = 4'b0010,
    ASD_READ = 4'b0100,
    ASD_REFRESH = 4'b1000
  } asd_state_t;

  // Compression mode, sets refresh pacing
  typedef enum logic [1:0] {
    ASD_FULL_BIT = 2'h0,
    ASD_SIX_BIT = 2'h1,
    ASD_FIVE_BIT = 2'h2,
    ASD_FOUR_BIT = 2'h3
  } asd_comp_t;

endpackage

// *** hw/asd_pair_buffer.sv ***
// Two-entry read-data buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
`include "asd_regs.svh"

module asd_pair_buffer (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [3:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Receiver takes word
  output logic [3:0] out_data // Head word
);

  logic [3:0] slot [0:1];
  logic [3:0] next_slot [0:1];
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic next_in_ready;
  logic next_out_valid;
  logic push;
  logic pop;
  logic [1:0] wr_idx;

  assign out_data = slot[0];

  // Shift on pop, write at the first free index
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_slot[0] = slot[0];
    next_slot[1] = slot[1];
    wr_idx = cnt - {1'b0, pop};
    if (pop) begin
      next_slot[0] = slot[1];
    end
    if (push) begin
      next_slot[wr_idx[0]] = in_data;
    end
    next_cnt = cnt + {1'b0, push} - {1'b0, pop};
    next_in_ready = next_cnt != `ASD_BUF_DEPTH;
    next_out_valid = next_cnt != 2'h0;
  end

  // Registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      slot[0] <= 4'h0;
      slot[1] <= 4'h0;
      cnt <= 2'h0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      slot[0] <= next_slot[0];
      slot[1] <= next_slot[1];
      cnt <= next_cnt;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
    end
  end

endmodule
`default_nettype wire

// *** hw/asd_dram_seq.sv ***
// Anti-shock DRAM access sequencer: strobes, address mux, data and refresh
`timescale 1ns/10ps
`default_nettype none
`include "asd_regs.svh"

module asd_dram_seq
  import asd_pkg::*;
(
  input wire logic sys_clk, // System clock, 25 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic memory_system_on, // High: shock-proof, low: through
  input wire logic dram_size_select, // High: 4M part, low: 1M part
  input wire logic [1:0] compression_mode, // Pacing mode, see asd_comp_t
  input wire logic req_valid, // Access request
  input wire logic req_write, // High: write, low: read
  input wire logic [19:0] req_address, // Nibble address
  input wire logic [3:0] req_wdata, // Nibble to write
  output logic req_ready, // Request taken when high with valid
  output logic rd_valid, // Read nibble available
  input wire logic rd_ready, // Receiver takes read nibble
  output logic [3:0] rd_data, // Read nibble
  output logic through_mode, // High while memory bypassed
  output logic row_strobe_n, // DRAM row strobe
  output logic column_strobe_n, // DRAM column strobe
  output logic dram_read_gate_n, // DRAM output enable
  output logic dram_write_strobe_n, // DRAM write enable
  output logic [9:0] dram_mux_address, // Multiplexed address
  input wire logic [3:0] dram_nibble_in, // Data bus level
  output logic [3:0] dram_nibble_out, // Data bus drive value
  output logic dram_nibble_oe_n // Low while driving data bus
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Row or column part of a nibble address for the selected size
  function automatic logic [9:0] asd_split(input logic [19:0] a, input logic big, input logic col);
    logic [9:0] r;
    if (big) begin
      r = col ? a[9:0] : a[19:10];
    end else begin
      r = col ? {1'b0, a[8:0]} : {1'b0, a[17:9]};
    end
    return r;
  endfunction

  // Cycles between row refreshes for the size and mode
  function automatic logic [8:0] asd_ref_interval(input logic big, input logic [1:0] mode);
    logic [8:0] r;
    unique case ({big, mode})
      {1'b0, ASD_FULL_BIT}: r = 9'(`ASD_REF_CYC(`ASD_TREF_1M_FULL_US, `ASD_ROWS_1M));
      {1'b0, ASD_SIX_BIT}: r = 9'(`ASD_REF_CYC(`ASD_TREF_1M_6B_US, `ASD_ROWS_1M));
      {1'b0, ASD_FIVE_BIT}: r = 9'(`ASD_REF_CYC(`ASD_TREF_1M_5B_US, `ASD_ROWS_1M));
      {1'b0, ASD_FOUR_BIT}: r = 9'(`ASD_REF_CYC(`ASD_TREF_1M_4B_US, `ASD_ROWS_1M));
      {1'b1, ASD_FULL_BIT}: r = 9'(`ASD_REF_CYC(`ASD_TREF_4M_FULL_US, `ASD_ROWS_4M));
      {1'b1, ASD_SIX_BIT}: r = 9'(`ASD_REF_CYC(`ASD_TREF_4M_6B_US, `ASD_ROWS_4M));
      {1'b1, ASD_FIVE_BIT}: r = 9'(`ASD_REF_CYC(`ASD_TREF_4M_5B_US, `ASD_ROWS_4M));
      {1'b1, ASD_FOUR_BIT}: r = 9'(`ASD_REF_CYC(`ASD_TREF_4M_4B_US, `ASD_ROWS_4M));
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  asd_state_t state;
  asd_state_t next_state;
  logic [3:0] phase;
  logic [3:0] next_phase;
  logic [19:0] addr_lat;
  logic [19:0] next_addr_lat;
  logic [3:0] wdata_lat;
  logic [3:0] next_wdata_lat;
  logic next_req_ready;
  logic next_through_mode;
  logic next_row_strobe_n;
  logic next_column_strobe_n;
  logic next_dram_read_gate_n;
  logic next_dram_write_strobe_n;
  logic [9:0] next_dram_mux_address;
  logic next_dram_nibble_oe_n;
  logic start_ref;
  logic cap_push;
  logic buf_in_ready;
  logic in_acc;
  logic col_acc;
  logic [9:0] ref_row_addr;

  logic [8:0] ref_timer;
  logic [8:0] next_ref_timer;
  logic ref_pend;
  logic next_ref_pend;
  logic [9:0] ref_row;
  logic [9:0] next_ref_row;
  logic ref_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  // Next state, latched request and next pin values
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_addr_lat = addr_lat;
    next_wdata_lat = wdata_lat;
    start_ref = 1'b0;
    cap_push = 1'b0;
    unique case (state)
      ASD_IDLE: begin
        if (memory_system_on && ref_pend) begin
          next_state = ASD_REFRESH;
          next_phase = `ASD_P_START;
          start_ref = 1'b1;
        end else if (req_valid && req_ready) begin
          next_state = req_write ? ASD_WRITE : ASD_READ;
          next_phase = `ASD_P_START;
          next_addr_lat = req_address;
          next_wdata_lat = req_wdata;
        end
      end
      ASD_WRITE, ASD_READ, ASD_REFRESH: begin
        cap_push = (state == ASD_READ) && (phase == `ASD_P_LAST_LOW);
        if (phase == `ASD_P_END) begin
          next_state = ASD_IDLE;
        end else begin
          next_phase = phase + `ASD_PHASE_STEP;
        end
      end
      default: begin
        next_state = ASD_IDLE;
        next_phase = `ASD_P_START;
      end
    endcase
    in_acc = next_state != ASD_IDLE;
    col_acc = (next_state == ASD_WRITE) || (next_state == ASD_READ);
    // Refresh row from the stepped count, so it stands unchanged across the RAS fall
    ref_row_addr = {dram_size_select & next_ref_row[9], next_ref_row[8:0]};
    // Strobe windows by phase
    next_row_strobe_n = !(in_acc && next_phase >= `ASD_P_RAS_FALL && next_phase <= `ASD_P_LAST_LOW);
    next_column_strobe_n = !(col_acc && next_phase >= `ASD_P_CAS_FALL && next_phase <= `ASD_P_LAST_LOW);
    next_dram_write_strobe_n = !(next_state == ASD_WRITE && next_phase <= `ASD_P_LAST_LOW);
    next_dram_read_gate_n = !(next_state == ASD_READ && next_phase <= `ASD_P_LAST_LOW);
    next_dram_nibble_oe_n = next_dram_write_strobe_n;
    // Row address around RAS fall, column address until hold ends
    next_dram_mux_address = dram_mux_address;
    if (in_acc && next_phase <= `ASD_P_ROW_HOLD) begin
      next_dram_mux_address = (next_state == ASD_REFRESH) ? ref_row_addr :
                              asd_split(next_addr_lat, dram_size_select, 1'b0);
    end else if (col_acc && next_phase <= `ASD_P_COL_END) begin
      next_dram_mux_address = asd_split(next_addr_lat, dram_size_select, 1'b1);
    end
    // Accept only when idle, in shock-proof mode, no refresh due, room for data
    next_req_ready = !in_acc && memory_system_on && !next_ref_pend && buf_in_ready;
    next_through_mode = !memory_system_on;
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ASD_IDLE;
      phase <= `ASD_P_START;
      addr_lat <= 20'h00000;
      wdata_lat <= 4'h0;
      req_ready <= 1'b0;
      through_mode <= 1'b1;
      row_strobe_n <= 1'b1;
      column_strobe_n <= 1'b1;
      dram_read_gate_n <= 1'b1;
      dram_write_strobe_n <= 1'b1;
      dram_mux_address <= 10'h000;
      dram_nibble_out <= 4'h0;
      dram_nibble_oe_n <= 1'b1;
    end else begin
      state <= next_state;
      phase <= next_phase;
      addr_lat <= next_addr_lat;
      wdata_lat <= next_wdata_lat;
      req_ready <= next_req_ready;
      through_mode <= next_through_mode;
      row_strobe_n <= next_row_strobe_n;
      column_strobe_n <= next_column_strobe_n;
      dram_read_gate_n <= next_dram_read_gate_n;
      dram_write_strobe_n <= next_dram_write_strobe_n;
      dram_mux_address <= next_dram_mux_address;
      dram_nibble_out <= next_wdata_lat;
      dram_nibble_oe_n <= next_dram_nibble_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh pacing

  // Interval timer, pending flag (set wins over clear), row counter
  always_comb begin
    ref_tick = 1'b0;
    next_ref_pend = ref_pend;
    next_ref_row = ref_row;
    if (!memory_system_on) begin
      next_ref_timer = asd_ref_interval(dram_size_select, compression_mode);
      next_ref_pend = 1'b0;
    end else begin
      if (ref_timer == 9'h000) begin
        next_ref_timer = asd_ref_interval(dram_size_select, compression_mode) - 9'h001;
        ref_tick = 1'b1;
      end else begin
        next_ref_timer = ref_timer - 9'h001;
      end
      next_ref_pend = (ref_pend && !start_ref) || ref_tick;
      if (start_ref) begin
        next_ref_row = ref_row + 10'h001;
      end
    end
  end

  // Refresh registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_timer <= 9'h000;
      ref_pend <= 1'b0;
      ref_row <= 10'h000;
    end else begin
      ref_timer <= next_ref_timer;
      ref_pend <= next_ref_pend;
      ref_row <= next_ref_row;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-data buffer; capture at the edge where CAS rises

  asd_pair_buffer u_rd_buf (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(cap_push),
    .in_ready(buf_in_ready),
    .in_data(dram_nibble_in),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking asd_cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  localparam int GAP_MAX = `ASD_REF_CYC_MAX + 12;
  logic [9:0] ref_gap;

  // Cycles since the last refresh start or the last cycle in through mode
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_gap <= 10'h000;
    end else if (start_ref || !memory_system_on) begin
      ref_gap <= 10'h000;
    end else begin
      ref_gap <= ref_gap + 10'h001;
    end
  end

  property p_ras_pulse;
    $fell(row_strobe_n) |-> !row_strobe_n [*5] ##1 row_strobe_n [*3];
  endproperty
  a_ras_pulse: assert property (p_ras_pulse) else $error("row strobe width wrong");

  property p_ras_to_cas;
    $fell(column_strobe_n) |-> $past(row_strobe_n, 3) && !$past(row_strobe_n, 2);
  endproperty
  a_ras_to_cas: assert property (p_ras_to_cas) else $error("column strobe not two after row");

  property p_row_addr;
    $fell(row_strobe_n) |-> $stable(dram_mux_address);
  endproperty
  a_row_addr: assert property (p_row_addr) else $error("row address not held");

  property p_col_addr;
    $fell(column_strobe_n) |-> $stable(dram_mux_address) [*5];
  endproperty
  a_col_addr: assert property (p_col_addr) else $error("column address not held");

  property p_write_data;
    $fell(column_strobe_n) && !dram_write_strobe_n |->
      ($past(dram_nibble_oe_n, 4) && !$past(dram_nibble_oe_n, 3)) ##0 (!dram_nibble_oe_n [*3]) ##1 dram_nibble_oe_n;
  endproperty
  a_write_data: assert property (p_write_data) else $error("write data window wrong");

  property p_cas_pulse;
    $fell(column_strobe_n) |-> !column_strobe_n [*3] ##1 column_strobe_n [*5];
  endproperty
  a_cas_pulse: assert property (p_cas_pulse) else $error("column strobe width wrong");

  property p_capture;
    cap_push |=> $rose(column_strobe_n) && rd_valid;
  endproperty
  a_capture: assert property (p_capture) else $error("read capture not at column rise");

  property p_we_pulse;
    $fell(dram_write_strobe_n) |-> (!dram_write_strobe_n [*6] ##1 dram_write_strobe_n) and
      (##3 $fell(column_strobe_n));
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe timing wrong");

  property p_oe_pulse;
    $fell(dram_read_gate_n) |-> !dram_read_gate_n [*6] ##1 dram_read_gate_n;
  endproperty
  a_oe_pulse: assert property (p_oe_pulse) else $error("read gate width wrong");

  property p_through;
    !memory_system_on |=> through_mode && !req_ready;
  endproperty
  a_through: assert property (p_through) else $error("through mode not entered");

  property p_small_row;
    $fell(row_strobe_n) && !$past(dram_size_select, 2) |-> !dram_mux_address[9];
  endproperty
  a_small_row: assert property (p_small_row) else $error("1M row address too wide");

  property p_ref_gap;
    ref_gap <= 10'(GAP_MAX);
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("refresh interval exceeded");

endmodule
`default_nettype wire

// *** verification/asd_dram_model.sv ***
// Page-mode DRAM partner model holding nibbles, answering reads promptly or late
`timescale 1ns/10ps
`default_nettype none

module asd_dram_model (
  input wire logic sys_clk, // System clock
  input wire logic row_strobe_n, // Row strobe
  input wire logic column_strobe_n, // Column strobe
  input wire logic dram_read_gate_n, // Output enable
  input wire logic dram_write_strobe_n, // Write enable
  input wire logic [9:0] dram_mux_address, // Multiplexed address
  input wire logic [3:0] dram_nibble_out, // Device drive value
  input wire logic dram_nibble_oe_n, // Device drives bus when low
  input wire logic slow, // Data only in the last column-low cycle
  output logic [3:0] dram_nibble_in // Bus level seen by the device
);
  logic [3:0] mem [logic [19:0]];
  logic [9:0] row = 10'h000;
  logic [9:0] col = 10'h000;
  logic [3:0] last = 4'h0;
  int cas_cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Latch the row, then the column; store a write at the column strobe
  always @(negedge row_strobe_n) begin
    row = dram_mux_address;
  end

  always @(negedge column_strobe_n) begin
    col = dram_mux_address;
    if (!dram_write_strobe_n && !dram_nibble_oe_n) begin
      mem[{row, col}] = dram_nibble_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus settles just after each rising clock edge; an undriven bus shows the inverse of its last value
  initial dram_nibble_in = 4'h0;
  always @(posedge sys_clk) begin
    #1;
    cas_cycles = column_strobe_n ? 0 : cas_cycles + 1;
    if (!dram_read_gate_n && !column_strobe_n && dram_nibble_oe_n && (!slow || cas_cycles >= 3)) begin
      last = mem.exists({row, col}) ? mem[{row, col}] : 4'h0;
      dram_nibble_in = last;
    end else begin
      dram_nibble_in = ~last;
    end
  end
endmodule
`default_nettype wire

// *** verification/asd_dram_seq_bench.sv ***
// Self-checking bench for the anti-shock DRAM access sequencer
`timescale 1ns/10ps
`default_nettype none

module asd_dram_seq_bench;
  import asd_pkg::*;
  logic sys_clk, reset_n, memory_system_on, dram_size_select, req_valid, req_write, req_ready, rd_valid, rd_ready;
  logic through_mode, row_strobe_n, column_strobe_n, dram_read_gate_n, dram_write_strobe_n, dram_nibble_oe_n, slow;
  logic [1:0] compression_mode;
  logic [19:0] req_address;
  logic [3:0] req_wdata, rd_data, dram_nibble_in, dram_nibble_out;
  logic [9:0] dram_mux_address;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [15:0] rnd = 16'h000b;
  logic rd_hold = 1'b1;
  logic [3:0] exp_q [$];
  logic [3:0] shadow [logic [19:0]];
  logic [19:0] al [6];
  int tref_us [8] = '{1400, 3700, 4400, 5500, 2700, 7300, 8800, 10900};

  asd_dram_seq i_dut (.sys_clk, .reset_n, .memory_system_on, .dram_size_select, .compression_mode, .req_valid,
    .req_write, .req_address, .req_wdata, .req_ready, .rd_valid, .rd_ready, .rd_data, .through_mode, .row_strobe_n,
    .column_strobe_n, .dram_read_gate_n, .dram_write_strobe_n, .dram_mux_address, .dram_nibble_in, .dram_nibble_out,
    .dram_nibble_oe_n);

  asd_dram_model i_mem (.sys_clk, .row_strobe_n, .column_strobe_n, .dram_read_gate_n, .dram_write_strobe_n,
    .dram_mux_address, .dram_nibble_out, .dram_nibble_oe_n, .slow, .dram_nibble_in);

  ////////////////////////////////////////////////////////////////////////////////
  // Random source, comparisons and verdict
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic tally(input logic bad, input string what, input logic [14:0] e, input logic [14:0] g);
    checks_done++;
    if (bad) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_vec(input string what, input logic [14:0] e, input logic [14:0] g);
    tally(g !== e, what, e, g);
  endtask

  task automatic check_nib(input string what, input logic [3:0] e, input logic [3:0] g);
    tally(g !== e, what, {11'h000, e}, {11'h000, g});
  endtask

  task automatic check_bit(input string what, input logic e, input logic g);
    tally(g !== e, what, {14'h0000, e}, {14'h0000, g});
  endtask

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One access: wait for acceptance, then check strobes, address and data cycle by cycle
  task automatic access(input logic w, input logic [19:0] a, input logic [3:0] d);
    logic [9:0] row, col;
    logic act;
    int n;
    row = dram_size_select ? a[19:10] : {1'b0, a[17:9]};
    col = dram_size_select ? a[9:0] : {1'b0, a[8:0]};
    req_valid = 1'b1;
    req_write = w;
    req_address = a;
    req_wdata = d;
    n = 0;
    while (req_ready !== 1'b1 && n < 600) begin
      @(negedge sys_clk);
      n++;
    end
    check_bit("request taken", 1'b1, req_ready);
    @(negedge sys_clk);
    req_valid = 1'b0;
    if (w) shadow[a] = d;
    else exp_q.push_back(shadow[a]);
    for (int c = 0; c < 8; c++) begin
      act = c <= 5;
      check_vec("strobes and address", {!(c >= 1 && act), !(c >= 3 && act), !(act && !w), !(act && w), !(act && w),
        (c <= 1) ? row : col}, {row_strobe_n, column_strobe_n, dram_read_gate_n, dram_write_strobe_n,
        dram_nibble_oe_n, dram_mux_address});
      if (w && act) check_nib("write nibble", d, dram_nibble_out);
      @(negedge sys_clk);
    end
  endtask

  // Cycles until the next falling row strobe, 1000 if none
  task automatic ras_fall(output int gap);
    logic prev;
    prev = 1'b0;
    gap = 0;
    while (!(prev && row_strobe_n === 1'b0) && gap < 1000) begin
      prev = row_strobe_n;
      @(negedge sys_clk);
      gap++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, receiver stalls at random, read results checked in order
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk) begin
    rnd <= lfsr(rnd);
    rd_ready <= !rd_hold && rnd[3];
  end

  always @(posedge sys_clk) begin
    if (reset_n === 1'b1 && rd_valid === 1'b1 && rd_ready === 1'b1) begin
      if (exp_q.size() == 0) check_bit("unexpected read nibble", 1'b0, 1'b1);
      else check_nib("read nibble", exp_q.pop_front(), rd_data);
    end
  end

  initial begin
    #(40 * 40000);
    n_mismatch++;
    $display("Error watchdog expected finish seen timeout");
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int g, g2, r1;
    reset_n = 1'b0;
    memory_system_on = 1'b1;
    dram_size_select = 1'b1;
    compression_mode = 2'h3;
    {req_valid, req_write, slow} = 3'h0;
    req_address = 20'h00000;
    req_wdata = 4'h0;
    repeat (3) @(negedge sys_clk);
    check_vec("reset strobes", {5'h1f, 10'h000}, {row_strobe_n, column_strobe_n, dram_read_gate_n,
      dram_write_strobe_n, dram_nibble_oe_n, dram_mux_address});
    check_bit("reset through flag", 1'b1, through_mode);
    reset_n = 1'b1;
    // Writes then reads on both part sizes, boundary addresses first
    for (int s = 1; s >= 0; s--) begin
      dram_size_select = s[0];
      shadow.delete();
      rd_hold = 1'b0;
      for (int i = 0; i < 6; i++) begin
        al[i] = (i == 0) ? 20'h00000 : (i == 1) ? (s ? 20'hfffff : 20'h3ffff) :
          ({rnd, rnd[3:0]} & (s ? 20'hfffff : 20'h3ffff));
        access(1'b1, al[i], rnd[11:8]);
      end
      for (int i = 0; i < 6; i++) begin
        slow = rnd[5];
        access(1'b0, al[i], 4'h0);
      end
      repeat (60) @(negedge sys_clk);
    end
    // Full read buffer refuses a third read until drained
    rd_hold = 1'b1;
    access(1'b0, al[2], 4'h0);
    access(1'b0, al[3], 4'h0);
    req_valid = 1'b1;
    repeat (30) begin
      @(negedge sys_clk);
      check_bit("ready with buffer full", 1'b0, req_ready);
    end
    req_valid = 1'b0;
    rd_hold = 1'b0;
    repeat (60) @(negedge sys_clk);
    // Refresh pacing and row stepping for every size and mode
    for (int m = 0; m < 8; m++) begin
      dram_size_select = m[2];
      compression_mode = m[1:0];
      ras_fall(g);
      ras_fall(g);
      r1 = dram_mux_address;
      ras_fall(g);
      g2 = tref_us[m] * 25 / (m[2] ? 1024 : 512);
      check_bit("refresh spacing", 1'b1, g <= g2 && g * 2 > g2);
      check_vec("refresh row step", 15'h0001, 15'((dram_mux_address - r1) & (m[2] ? 10'h3ff : 10'h1ff)));
    end
    // Through mode: no requests, no refresh
    memory_system_on = 1'b0;
    @(negedge sys_clk);
    check_bit("through flag", 1'b1, through_mode);
    check_bit("ready in through mode", 1'b0, req_ready);
    ras_fall(g);
    check_bit("row strobe idle", 1'b1, g == 1000);
    memory_system_on = 1'b1;
    @(negedge sys_clk);
    check_bit("through flag off", 1'b0, through_mode);
    check_bit("all reads returned", 1'b1, exp_q.size() == 0);
    test_done();
  end
endmodule
`default_nettype wire
